// [test/rbw_board_model.sv]
// Board side of the reset, boot and watchdog block: straps and reset pull.
// Assumes an open drain reset pin with a board pull-up.
`timescale 1ns/1ps
module rbw_board_model (
  input wire logic narrowSel,
  input wire logic [2:0] wideCode,
  input wire logic [1:0] thinCode,
  input wire logic pullReq,
  input wire logic deviceOe,
  output logic narrowPackage,
  output logic [2:0] boot_select_pins,
  output logic [1:0] boot_select_pins_narrow,
  output logic pinLevel
);
  // -----------------------------------------------------------------
  // Straps and shared pin
  // -----------------------------------------------------------------
  // Straps sit at the intended boot code
  assign narrowPackage = narrowSel;
  assign boot_select_pins = wideCode;
  assign boot_select_pins_narrow = thinCode;
  // Pull-up wins unless either side pulls the pin low
  assign pinLevel = !(deviceOe || pullReq);
endmodule : rbw_board_model

// [test/tb.sv]
// Self-checking bench for the reset, boot and watchdog block.
// Assumes the board model in rbw_board_model.sv and the design header.
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    rbw_pkg::rbw_boot_t mode;
    logic boot;
    logic pll;
    logic run;
    logic expd;
  } rbw_note_t;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic narrowSel = 1'b0;
  logic [2:0] wideCode = 3'h0;
  logic [1:0] thinCode = 2'h0;
  logic pullReq = 1'b0;
  logic wdogLoad = 1'b0;
  logic wdogEnableSet = 1'b0;
  logic wdogEnableClear = 1'b0;
  logic pinOut;
  logic wdogReload = 1'b0;
  logic [31:0] wdogLoadValue = 32'h0;
  logic narrowPackage, pinLevel, pinOe, wdogEnabled, wdogExpired, bootStart;
  logic coreReset, periphReset, pllSdramReset, runningResetActive;
  logic [2:0] bootPins;
  logic [1:0] bootPinsNarrow;
  logic [31:0] wdogCount, val;
  rbw_pkg::rbw_boot_t bootMode, curMode;
  rbw_note_t notes[$];
  rbw_note_t seen, want;
  logic prevCore = 1'b0;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 89;

  initial forever #12.5 clock = ~clock;

  rbw_board_model board_u (.narrowSel(narrowSel), .wideCode(wideCode), .thinCode(thinCode),
    .pullReq(pullReq), .deviceOe(pinOe), .narrowPackage(narrowPackage),
    .boot_select_pins(bootPins), .boot_select_pins_narrow(bootPinsNarrow), .pinLevel(pinLevel));

  rbw_reset_boot_watchdog dut_u (.clock(clock), .reset_n(reset_n), .narrowPackage(narrowPackage),
    .boot_select_pins(bootPins), .boot_select_pins_narrow(bootPinsNarrow),
    .reset_out_or_warm_reset_in_in(pinLevel), .reset_out_or_warm_reset_in_out(pinOut),
    .reset_out_or_warm_reset_in_oe(pinOe), .wdogLoad(wdogLoad), .wdogLoadValue(wdogLoadValue),
    .wdogEnableSet(wdogEnableSet), .wdogEnableClear(wdogEnableClear), .wdogReload(wdogReload),
    .wdogCount(wdogCount), .wdogEnabled(wdogEnabled), .wdogExpired(wdogExpired),
    .coreReset(coreReset), .periphReset(periphReset), .pllSdramReset(pllSdramReset),
    .bootMode(bootMode), .bootStart(bootStart), .runningResetActive(runningResetActive));

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // Strap decode worked out independently of the design
  function automatic rbw_pkg::rbw_boot_t decode();
    if (narrowSel)
      return thinCode == 2'h2 ? rbw_pkg::BOOT_RESERVED : thinCode == 2'h3 ? rbw_pkg::BOOT_ROM :
        rbw_pkg::rbw_boot_t'({1'b0, thinCode});
    return wideCode[2] ? rbw_pkg::BOOT_RESERVED : rbw_pkg::rbw_boot_t'({1'b0, wideCode[1:0]});
  endfunction : decode

  // Bounded wait until every noted reset episode has ended
  task settle;
    int k;
    for (k = 0; k < 300 && (notes.size() != 0 || coreReset !== 1'b0); k++) @(negedge clock);
    chk(k < 300, "reset episode never ended");
  endtask : settle

  task power_up;
    @(negedge clock);
    reset_n = 1'b0;
    curMode = decode();
    notes.push_back('{curMode, curMode != rbw_pkg::BOOT_ROM, 1'b1, 1'b0, 1'b0});
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    settle();
  endtask : power_up

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // -----------------------------------------------------------------
  // Watcher: one note is compared as each reset episode ends
  // -----------------------------------------------------------------
  always @(negedge clock)
  begin
    if (coreReset === 1'b1 && prevCore !== 1'b1)
      seen = '0;
    if (coreReset === 1'b1)
      seen = seen | {3'h0, 1'b0, pllSdramReset, runningResetActive, wdogExpired};
    if (periphReset !== coreReset) chk(1'b0, "peripheral reset differs from core");
    // Device pulls the shared pin in its own resets, never in a requested one
    if (coreReset === 1'b1 && prevCore !== 1'b1 && reset_n === 1'b1)
      chk(pinOe === !runningResetActive && pinOut === 1'b0, "reset pin drive");
    if (coreReset === 1'b0 && prevCore === 1'b1)
    begin
      chk(notes.size() != 0, "unexpected reset");
      want = notes.size() != 0 ? notes.pop_front() : '0;
      chk(bootMode === want.mode, "boot mode");
      chk(bootStart === want.boot || want.mode == rbw_pkg::BOOT_RESERVED, "boot start");
      chk(seen.pll === want.pll && seen.run === want.run, "reset scope");
      chk(seen.expd === want.expd, "expiry pulse");
    end
    prevCore = coreReset;
  end

  // Timeout guard; the tests need about 600 cycles
  always @(negedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 12; i++)
    begin
      narrowSel = (i >= 8);
      wideCode = i[2:0];
      thinCode = i[1:0];
      power_up();
    end
    $display("strap decode test done");
    val = 32'h5 + ({$random(seed)} % 30);
    @(negedge clock);
    wdogLoadValue = val;
    wdogLoad = 1'b1;
    @(negedge clock);
    wdogLoad = 1'b0;
    repeat (3) @(negedge clock);
    chk(wdogCount === val && wdogEnabled === 1'b0, "count moved while disabled");
    wdogEnableSet = 1'b1;
    @(negedge clock);
    wdogEnableSet = 1'b0;
    repeat (2) @(negedge clock);
    chk(wdogCount === val - 32'h2, "down count");
    wdogEnableClear = 1'b1;
    @(negedge clock);
    wdogEnableClear = 1'b0;
    repeat (2) @(negedge clock);
    chk(wdogCount === val - 32'h3 && wdogEnabled === 1'b0, "clear did not stop count");
    wdogEnableSet = 1'b1;
    @(negedge clock);
    wdogEnableSet = 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      repeat (val - 4) @(negedge clock);
      wdogReload = 1'b1;
      @(negedge clock);
      wdogReload = 1'b0;
      chk(wdogCount === val, "reload value");
    end
    notes.push_back('{curMode, 1'b0, 1'b0, 1'b0, 1'b1});
    settle();
    chk(wdogEnabled === 1'b0, "enable survived expiry");
    $display("watchdog test done");
    for (int r = 0; r < 2; r++)
    begin
      narrowSel = 1'b0;
      wideCode = $random(seed);
      @(negedge clock);
      pullReq = 1'b1;
      notes.push_back('{curMode, 1'b0, 1'b0, 1'b1, 1'b0});
      repeat (3) @(negedge clock);
      pullReq = 1'b0;
      settle();
    end
    $display("running reset test done");
    finish_test();
  end
endmodule : tb

// [verilog/rbw_map.svh]
// Constants for the reset, boot and watchdog block.
// Assumes inclusion by bare name from files under verilog/.
`ifndef RBW_MAP_SVH
`define RBW_MAP_SVH
// -----------------------------------------------------------------
// Boot strap codes, wide (three pin) variant
// -----------------------------------------------------------------
`define RBW_W_SPI_SLAVE 3'h0
`define RBW_W_SPI_MASTER 3'h1
`define RBW_W_PARALLEL 3'h2
`define RBW_W_ROM 3'h3
// -----------------------------------------------------------------
// Boot strap codes, narrow (two pin) variant
// -----------------------------------------------------------------
`define RBW_N_SPI_SLAVE 2'h0
`define RBW_N_SPI_MASTER 2'h1
`define RBW_N_ROM 2'h3
// -----------------------------------------------------------------
// Reset timing and reset values
// -----------------------------------------------------------------
`define RBW_PWR_HOLD_CYCLES 8'h10
`define RBW_SYS_HOLD_CYCLES 8'h10
`define RBW_WDOG_RESET_COUNT 32'hffffffff
`endif

// [verilog/rbw_pkg.sv]
// Types for the reset, boot and watchdog block.
// Assumes no other package; constants live in rbw_map.svh.
package rbw_pkg;
  // Decoded boot source
  typedef enum logic [2:0] {
    BOOT_SPI_SLAVE,
    BOOT_SPI_MASTER,
    BOOT_PARALLEL,
    BOOT_ROM,
    BOOT_RESERVED
  } rbw_boot_t;
  // Reset sequencer phase
  typedef enum logic [1:0] {
    PH_POWER,
    PH_RUN,
    PH_SYSTEM
  } rbw_phase_t;
endpackage : rbw_pkg

// [verilog/rbw_reset_boot_watchdog.sv]
// Reset sequencer, boot strap decoder and software watchdog.
// Assumes all inputs but reset_n synchronous to clock; the shared reset pin is
// open drain, resolved outside, and reads low while anyone pulls it.
`timescale 1ns/1ps
`include "rbw_map.svh"

// Contract
// - Watchdog is 32-bit down counter
// - Reload restores count, preventing expiry
// - Load while disabled, count after enable
// - Expiry resets core and peripherals
// - Boot from parallel, SPI master, SPI slave
// - Three-pin strap decode, 1xx reserved
// - Two-pin strap decode, 10 reserved
// - Running reset spares PLL, SDRAM, boot
// - Reset pin also requests running reset
module rbw_reset_boot_watchdog #(
  parameter int WDOG_WIDTH = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic narrowPackage,
  input wire logic [2:0] boot_select_pins,
  input wire logic [1:0] boot_select_pins_narrow,
  input wire logic reset_out_or_warm_reset_in_in,
  output logic reset_out_or_warm_reset_in_out,
  output logic reset_out_or_warm_reset_in_oe,
  input wire logic wdogLoad,
  input wire logic [WDOG_WIDTH-1:0] wdogLoadValue,
  input wire logic wdogEnableSet,
  input wire logic wdogEnableClear,
  input wire logic wdogReload,
  output logic [WDOG_WIDTH-1:0] wdogCount,
  output logic wdogEnabled,
  output logic wdogExpired,
  output logic coreReset,
  output logic periphReset,
  output logic pllSdramReset,
  output rbw_pkg::rbw_boot_t bootMode,
  output logic bootStart,
  output logic runningResetActive
);

  // -----------------------------------------------------------------
  // Reset release synchroniser
  // -----------------------------------------------------------------
  logic resetMeta;
  logic resetSync;

  // Two stages so the release never lands near a clock edge
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resetMeta <= 1'b0;
      resetSync <= 1'b0;
    end
    else
    begin
      resetMeta <= 1'b1;
      resetSync <= resetMeta;
    end
  end

  // -----------------------------------------------------------------
  // Strap decoding
  // -----------------------------------------------------------------
  // Used for both variants so reserved codes map the same way
  function automatic rbw_pkg::rbw_boot_t decode_boot(
    input logic narrow,
    input logic [2:0] wide,
    input logic [1:0] thin
  );
    rbw_pkg::rbw_boot_t mode;
    mode = rbw_pkg::BOOT_RESERVED;
    if (narrow)
    begin
      unique case (thin)
        `RBW_N_SPI_SLAVE: mode = rbw_pkg::BOOT_SPI_SLAVE;
        `RBW_N_SPI_MASTER: mode = rbw_pkg::BOOT_SPI_MASTER;
        `RBW_N_ROM: mode = rbw_pkg::BOOT_ROM;
        default: mode = rbw_pkg::BOOT_RESERVED;
      endcase
    end
    else
    begin
      unique case (wide)
        `RBW_W_SPI_SLAVE: mode = rbw_pkg::BOOT_SPI_SLAVE;
        `RBW_W_SPI_MASTER: mode = rbw_pkg::BOOT_SPI_MASTER;
        `RBW_W_PARALLEL: mode = rbw_pkg::BOOT_PARALLEL;
        `RBW_W_ROM: mode = rbw_pkg::BOOT_ROM;
        default: mode = rbw_pkg::BOOT_RESERVED;
      endcase
    end
    return mode;
  endfunction : decode_boot

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    rbw_pkg::rbw_phase_t phase;
    logic [7:0] hold;
    logic [WDOG_WIDTH-1:0] count;
    logic [WDOG_WIDTH-1:0] start;
    logic enable;
    logic expired;
    logic core;
    logic periph;
    logic pll;
    logic pinDrive;
    logic pinPrev;
    logic warm;
    logic boot;
    rbw_pkg::rbw_boot_t mode;
  } rbw_state_t;

  rbw_state_t state;
  rbw_state_t next_state;
  logic pinLow;

  // Own drive reads back low, so only a foreign pull counts as a request
  assign pinLow = !reset_out_or_warm_reset_in_in && !state.pinDrive;

  // Sequencer and watchdog next state
  always_comb
  begin
    next_state = state;
    next_state.expired = 1'b0;
    next_state.boot = 1'b0;
    next_state.pinPrev = pinLow;
    unique case (state.phase)
      rbw_pkg::PH_POWER:
      begin
        next_state.pll = 1'b0;
        if (state.hold == 8'h00)
        begin
          // Straps caught exactly once, here; held until next power-up
          next_state.mode = decode_boot(narrowPackage, boot_select_pins,
            boot_select_pins_narrow);
          next_state.hold = 8'h01;
        end
        else if (state.hold == `RBW_PWR_HOLD_CYCLES)
        begin
          next_state.phase = rbw_pkg::PH_RUN;
          next_state.core = 1'b0;
          next_state.periph = 1'b0;
          next_state.boot = (state.mode != rbw_pkg::BOOT_ROM);
          next_state.pinDrive = 1'b0; // Free the shared pin for requests
          next_state.hold = 8'h00;
        end
        else
          next_state.hold = state.hold + 8'h01;
      end
      rbw_pkg::PH_RUN:
      begin
        if (wdogLoad && !state.enable)
        begin
          next_state.start = wdogLoadValue;
          next_state.count = wdogLoadValue;
        end
        if (state.enable && state.count == '0)
        begin
          // Expiry outranks any reload arriving in the same cycle
          next_state.expired = 1'b1;
          next_state.enable = 1'b0;
          next_state.phase = rbw_pkg::PH_SYSTEM;
          next_state.core = 1'b1;
          next_state.periph = 1'b1;
          next_state.pinDrive = 1'b1;
          next_state.hold = 8'h00;
        end
        else if (pinLow && !state.pinPrev)
        begin
          next_state.phase = rbw_pkg::PH_SYSTEM;
          next_state.core = 1'b1;
          next_state.periph = 1'b1;
          next_state.warm = 1'b1;
          next_state.enable = 1'b0;
          next_state.hold = 8'h00;
        end
        else
        begin
          if (wdogEnableSet)
            next_state.enable = 1'b1;
          else if (wdogEnableClear)
            next_state.enable = 1'b0;
          if (state.enable && wdogReload)
            next_state.count = state.start;
          else if (state.enable)
            next_state.count = state.count - 1'b1;
        end
      end
      rbw_pkg::PH_SYSTEM:
      begin
        // PLL reset and boot stay untouched in this phase
        if (state.hold == `RBW_SYS_HOLD_CYCLES)
        begin
          next_state.phase = rbw_pkg::PH_RUN;
          next_state.core = 1'b0;
          next_state.periph = 1'b0;
          next_state.pinDrive = 1'b0;
          next_state.warm = 1'b0;
          next_state.hold = 8'h00;
        end
        else
          next_state.hold = state.hold + 8'h01;
      end
    endcase
  end

  // Held in power-up phase until the synchronised release
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= '{phase: rbw_pkg::PH_POWER, hold: 8'h00,
        count: `RBW_WDOG_RESET_COUNT, start: `RBW_WDOG_RESET_COUNT,
        enable: 1'b0, expired: 1'b0, core: 1'b1, periph: 1'b1,
        pll: 1'b1, pinDrive: 1'b1, pinPrev: 1'b0, warm: 1'b0,
        boot: 1'b0, mode: rbw_pkg::BOOT_RESERVED};
    end
    else if (resetSync)
      state <= next_state;
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign reset_out_or_warm_reset_in_out = 1'b0;
  assign reset_out_or_warm_reset_in_oe = state.pinDrive;
  assign wdogCount = state.count;
  assign wdogEnabled = state.enable;
  assign wdogExpired = state.expired;
  assign coreReset = state.core;
  assign periphReset = state.periph;
  assign pllSdramReset = state.pll;
  assign bootMode = state.mode;
  assign bootStart = state.boot;
  assign runningResetActive = state.warm;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetSync);

  wdog_count_down_a: assert property (
    state.phase == rbw_pkg::PH_RUN && state.enable && state.count != '0
    && !wdogReload && !pinLow |=> state.count == $past(state.count) - 1'b1)
    else $error("watchdog did not count down");
  wdog_reload_a: assert property (
    state.phase == rbw_pkg::PH_RUN && state.enable && state.count != '0
    && wdogReload && !pinLow |=> state.count == state.start)
    else $error("reload did not restore count");
  wdog_idle_hold_a: assert property (
    state.phase == rbw_pkg::PH_RUN && !state.enable && !wdogLoad
    |=> state.count == $past(state.count))
    else $error("disabled watchdog changed count");
  wdog_expiry_reset_a: assert property (
    state.phase == rbw_pkg::PH_RUN && state.enable && state.count == '0
    |=> wdogExpired && coreReset && periphReset ##1 coreReset[*8])
    else $error("expiry did not reset core");
  wide_decode_a: assert property (
    resetSync && state.phase == rbw_pkg::PH_POWER && state.hold == 8'h00 && !narrowPackage
    && boot_select_pins[2] |=> bootMode == rbw_pkg::BOOT_RESERVED)
    else $error("reserved wide code not reserved");
  narrow_decode_a: assert property (
    resetSync && state.phase == rbw_pkg::PH_POWER && state.hold == 8'h00 && narrowPackage
    && boot_select_pins_narrow == `RBW_N_ROM |=> bootMode == rbw_pkg::BOOT_ROM)
    else $error("narrow rom code misdecoded");
  running_spares_a: assert property (
    state.phase == rbw_pkg::PH_SYSTEM |-> !pllSdramReset && !bootStart)
    else $error("running reset touched pll or boot");
  warm_request_a: assert property (
    state.phase == rbw_pkg::PH_RUN && pinLow && !state.pinPrev
    && !(state.enable && state.count == '0)
    |=> coreReset && runningResetActive)
    else $error("pin request not honoured");
  strap_stable_a: assert property (
    state.phase != rbw_pkg::PH_POWER |=> $stable(bootMode))
    else $error("boot mode changed after power-up");
  enable_cleared_a: assert property (
    wdogExpired |-> !wdogEnabled)
    else $error("enable survived watchdog reset");

  boot_seen_c: cover property (bootStart);
  expiry_seen_c: cover property (wdogExpired);
  warm_seen_c: cover property (runningResetActive && coreReset);
  reload_seen_c: cover property (wdogEnabled && wdogReload);

endmodule : rbw_reset_boot_watchdog
